// file: src/timer8_consts.svh
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL    3'h0
`define OFS_CMPA    3'h1
`define OFS_CMPB    3'h2
`define OFS_COUNT   3'h3
`define OFS_FLAGS   3'h4
`define OFS_IEN     3'h5
`define OFS_PINCTL  3'h6
// ****************************************
// Field positions
// ****************************************
`define CTRL_MODE   2:0
`define CTRL_ACTB   5:4
`define CTRL_ACTA   7:6
`define FLG_OVF     0
`define FLG_CMPA    1
`define FLG_CMPB    2
`define PIN_DIRA    0
`define PIN_DIRB    1
`define PIN_PORTA   2
`define PIN_PORTB   3
`define PIN_STA     4
`define PIN_STB     5
// ****************************************
// Values
// ****************************************
`define CNT_MAX     8'hff
`define CNT_BOTTOM  8'h00
`define CNT_ONE     8'h01
`define MODE_PCMAX  3'h1
`define MODE_CTC    3'h2
`define MODE_FASTMX 3'h3
`define MODE_PCOCR  3'h5
`define MODE_FASTOC 3'h7
`define ACT_NONE    2'h0
`define ACT_TOGGLE  2'h1
`endif

// file: src/timer8_pkg.sv
package timer8_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PC} wave_kind_e;
   typedef struct packed {
      byte_t      cnt;
      logic       dirUp;
      byte_t      ocrA;
      byte_t      ocrB;
      byte_t      bufA;
      byte_t      bufB;
      logic [2:0] mode;
      logic [1:0] actA;
      logic [1:0] actB;
      logic [2:0] ien;
      logic [2:0] flags;
      logic       stA;
      logic       stB;
      logic       dirA;
      logic       dirB;
      logic       portA;
      logic       portB;
      logic       pinA;
      logic       pinB;
      logic       oeA;
      logic       oeB;
      logic       irq;
      byte_t      rdata;
   } state_s;
endpackage

// file: src/timer8_waveform_modes.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "timer8_consts.svh"
module timer8_waveform_modes #(
   parameter int ADDR_W = 3
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  timerTick,
   input  wire logic [ADDR_W-1:0]     regAddr,
   input  wire timer8_pkg::byte_t     regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output timer8_pkg::byte_t          regRdata,
   output logic                       waveOutA,
   output logic                       waveOeA_n,
   output logic                       waveOutB,
   output logic                       waveOeB_n,
   output logic                       irqReq
);
   import timer8_pkg::*;

   // ****************************************
   // Parameter check
   // ****************************************
   if (ADDR_W < 3) begin : g_bad_addr
      $error("ADDR_W must be at least 3");
   end

   // ****************************************
   // Decoding helpers
   // ****************************************
   function automatic wave_kind_e kindOf(input logic [2:0] m);
      case (m)
         `MODE_CTC:    kindOf = KIND_CTC;
         `MODE_FASTMX: kindOf = KIND_FAST;
         `MODE_FASTOC: kindOf = KIND_FAST;
         `MODE_PCMAX:  kindOf = KIND_PC;
         `MODE_PCOCR:  kindOf = KIND_PC;
         default:      kindOf = KIND_NORMAL;
      endcase
   endfunction

   function automatic byte_t topOf(input logic [2:0] m, input byte_t ocr);
      if (m == `MODE_FASTOC || m == `MODE_PCOCR) begin
         topOf = ocr;
      end else begin
         topOf = `CNT_MAX;
      end
   endfunction

   function automatic logic waveNext(input logic       st,
                                     input logic [1:0] act,
                                     input wave_kind_e k,
                                     input logic       match,
                                     input logic       atTop,
                                     input logic       bottom,
                                     input logic       up,
                                     input logic       isA);
      waveNext = st;
      if (act != `ACT_NONE) begin
         case (k)
            KIND_FAST: begin
               if (act == `ACT_TOGGLE) begin
                  if (isA && match) begin
                     waveNext = ~st;
                  end
               end else if (atTop) begin
                  waveNext = ~act[0];
               end else if (match) begin
                  waveNext = act[0];
               end
            end
            KIND_PC: begin
               if (act[1]) begin
                  if (match) begin
                     waveNext = up ? act[0] : ~act[0];
                  end else if (bottom) begin
                     waveNext = ~act[0];
                  end
               end
            end
            default: begin
               if (match) begin
                  waveNext = (act == `ACT_TOGGLE) ? ~st : act[0];
               end
            end
         endcase
      end
   endfunction

   // ****************************************
   // State
   // ****************************************
   state_s     s_r;
   state_s     s_nxt;
   wave_kind_e kind;
   byte_t      top;
   logic       hit;
   logic       matchA;
   logic       matchB;
   logic       atTop;
   logic       bottom;

   assign kind   = kindOf(s_r.mode);
   assign top    = topOf(s_r.mode, s_r.ocrA);
   assign hit    = timerTick;
   assign matchA = hit && (s_r.cnt == s_r.ocrA);
   assign matchB = hit && (s_r.cnt == s_r.ocrB);

   always_comb begin
      s_nxt = s_r;
      atTop  = 1'b0;
      bottom = 1'b0;

      // ****************************************
      // Software writes
      // ****************************************
      if (regWr) begin
         case (regAddr[2:0])
            `OFS_CTRL: begin
               s_nxt.mode = regWdata[`CTRL_MODE];
               s_nxt.actA = regWdata[`CTRL_ACTA];
               s_nxt.actB = regWdata[`CTRL_ACTB];
            end
            `OFS_CMPA: begin
               s_nxt.bufA = regWdata;
               if (kind == KIND_NORMAL || kind == KIND_CTC) begin
                  s_nxt.ocrA = regWdata;
               end
            end
            `OFS_CMPB: begin
               s_nxt.bufB = regWdata;
               if (kind == KIND_NORMAL || kind == KIND_CTC) begin
                  s_nxt.ocrB = regWdata;
               end
            end
            `OFS_FLAGS: s_nxt.flags = s_r.flags & ~regWdata[2:0];
            `OFS_IEN:   s_nxt.ien = regWdata[2:0];
            `OFS_PINCTL: begin
               s_nxt.dirA  = regWdata[`PIN_DIRA];
               s_nxt.dirB  = regWdata[`PIN_DIRB];
               s_nxt.portA = regWdata[`PIN_PORTA];
               s_nxt.portB = regWdata[`PIN_PORTB];
            end
            default: ;
         endcase
      end

      // ****************************************
      // Counter
      // ****************************************
      if (hit) begin
         case (kind)
            KIND_CTC: begin
               if (s_r.cnt == s_r.ocrA) begin
                  s_nxt.cnt = `CNT_BOTTOM;
               end else begin
                  s_nxt.cnt = s_r.cnt + `CNT_ONE;
               end
               if (s_r.cnt == `CNT_MAX) begin
                  s_nxt.flags[`FLG_OVF] = 1'b1;
               end
            end
            KIND_FAST: begin
               atTop = (s_r.cnt == top);
               if (atTop) begin
                  s_nxt.cnt = `CNT_BOTTOM;
                  s_nxt.flags[`FLG_OVF] = 1'b1;
                  s_nxt.ocrA = s_r.bufA;
                  s_nxt.ocrB = s_r.bufB;
               end else begin
                  s_nxt.cnt = s_r.cnt + `CNT_ONE;
               end
            end
            KIND_PC: begin
               if (top == `CNT_BOTTOM) begin
                  s_nxt.cnt   = `CNT_BOTTOM;
                  s_nxt.dirUp = 1'b1;
                  s_nxt.flags[`FLG_OVF] = 1'b1;
               end else if (s_r.dirUp) begin
                  if (s_r.cnt == top) begin
                     s_nxt.cnt   = top - `CNT_ONE;
                     s_nxt.dirUp = 1'b0;
                     s_nxt.ocrA  = s_r.bufA;
                     s_nxt.ocrB  = s_r.bufB;
                  end else begin
                     s_nxt.cnt = s_r.cnt + `CNT_ONE;
                  end
               end else if (s_r.cnt == `CNT_BOTTOM) begin
                  bottom      = 1'b1;
                  s_nxt.cnt   = `CNT_ONE;
                  s_nxt.dirUp = 1'b1;
                  s_nxt.flags[`FLG_OVF] = 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt - `CNT_ONE;
               end
            end
            default: begin
               s_nxt.cnt = s_r.cnt + `CNT_ONE;
               if (s_r.cnt == `CNT_MAX) begin
                  s_nxt.flags[`FLG_OVF] = 1'b1;
               end
            end
         endcase
      end
      if (kind != KIND_PC) begin
         s_nxt.dirUp = 1'b1;
      end

      // ****************************************
      // Compare flags, set wins over clear
      // ****************************************
      if (matchA) begin
         s_nxt.flags[`FLG_CMPA] = 1'b1;
      end
      if (matchB) begin
         s_nxt.flags[`FLG_CMPB] = 1'b1;
      end

      // ****************************************
      // Waveform state
      // ****************************************
      s_nxt.stA = waveNext(s_r.stA, s_r.actA, kind, matchA, atTop, bottom && s_r.ocrA != `CNT_BOTTOM,
                           s_nxt.dirUp, 1'b1);
      s_nxt.stB = waveNext(s_r.stB, s_r.actB, kind, matchB, atTop, bottom && s_r.ocrB != `CNT_BOTTOM,
                           s_nxt.dirUp, 1'b0);

      // ****************************************
      // Pins
      // ****************************************
      s_nxt.pinA = (s_nxt.actA != `ACT_NONE) ? s_nxt.stA : s_nxt.portA;
      s_nxt.pinB = (s_nxt.actB != `ACT_NONE) ? s_nxt.stB : s_nxt.portB;
      s_nxt.oeA  = ~s_nxt.dirA;
      s_nxt.oeB  = ~s_nxt.dirB;
      s_nxt.irq  = |(s_nxt.flags & s_nxt.ien);

      // ****************************************
      // Read data
      // ****************************************
      s_nxt.rdata = '0;
      if (regRd) begin
         case (regAddr[2:0])
            `OFS_CTRL:   s_nxt.rdata = {s_r.actA, s_r.actB, 1'b0, s_r.mode};
            `OFS_CMPA:   s_nxt.rdata = s_r.bufA;
            `OFS_CMPB:   s_nxt.rdata = s_r.bufB;
            `OFS_COUNT:  s_nxt.rdata = s_r.cnt;
            `OFS_FLAGS:  s_nxt.rdata = {5'h00, s_r.flags};
            `OFS_IEN:    s_nxt.rdata = {5'h00, s_r.ien};
            `OFS_PINCTL: s_nxt.rdata = {2'h0, s_r.stB, s_r.stA, s_r.portB, s_r.portA, s_r.dirB, s_r.dirA};
            default:     s_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_r       <= '0;
         s_r.dirUp <= 1'b1;
         s_r.oeA   <= 1'b1;
         s_r.oeB   <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regRdata  = s_r.rdata;
   assign waveOutA  = s_r.pinA;
   assign waveOeA_n = s_r.oeA;
   assign waveOutB  = s_r.pinB;
   assign waveOeB_n = s_r.oeB;
   assign irqReq    = s_r.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_ctc_clear: assert property (
      kind == KIND_CTC && hit && s_r.cnt == s_r.ocrA |=> s_r.cnt == `CNT_BOTTOM)
      else $error("counter not cleared on compare A match");
   a_cmpa_flag: assert property (
      matchA |=> s_r.flags[`FLG_CMPA])
      else $error("compare A flag not set");
   a_ctc_toggle: assert property (
      kind == KIND_CTC && matchA && s_r.actA == `ACT_TOGGLE |=> s_r.stA != $past(s_r.stA))
      else $error("output A did not toggle");
   a_pin_drive: assert property (
      regWr && regAddr[2:0] == `OFS_PINCTL |=> waveOeA_n == !$past(regWdata[`PIN_DIRA]))
      else $error("pin enable does not follow direction");
   a_ctc_ovf: assert property (
      kind == KIND_CTC && hit && s_r.cnt == `CNT_MAX |=> s_r.flags[`FLG_OVF] && s_r.cnt == `CNT_BOTTOM)
      else $error("overflow flag missing at wrap");
   a_fast_wrap: assert property (
      kind == KIND_FAST && hit && s_r.cnt == top |=> s_r.cnt == `CNT_BOTTOM && s_r.flags[`FLG_OVF])
      else $error("fast mode did not return to bottom");
   a_pc_reverse: assert property (
      kind == KIND_PC && hit && s_r.dirUp && s_r.cnt == top && top != `CNT_BOTTOM
      |=> !s_r.dirUp && s_r.cnt == $past(top) - `CNT_ONE)
      else $error("counter did not reverse after top");
   a_pc_ovf: assert property (
      kind == KIND_PC && hit && !s_r.dirUp && s_r.cnt == `CNT_BOTTOM |=> s_r.flags[`FLG_OVF] && s_r.dirUp)
      else $error("overflow flag missing at bottom");
   a_hold_tick: assert property (
      !hit && !regWr |=> $stable(s_r.cnt) && $stable(s_r.stA))
      else $error("counter moved without tick");
   a_act_none: assert property (
      s_r.actA == `ACT_NONE && !regWr |=> $stable(s_r.stA))
      else $error("output changed with no action");
   a_ctc_direct: assert property (
      regWr && regAddr[2:0] == `OFS_CMPA && (kind == KIND_CTC || kind == KIND_NORMAL)
      |=> s_r.ocrA == $past(regWdata))
      else $error("unbuffered compare write did not land");
   a_pwm_buffer: assert property (
      regWr && regAddr[2:0] == `OFS_CMPA && (kind == KIND_FAST || kind == KIND_PC) && s_r.cnt != top
      |=> $stable(s_r.ocrA) && s_r.bufA == $past(regWdata))
      else $error("buffered compare changed before top");
   a_fast_count: assert property (
      kind == KIND_FAST && hit && s_r.cnt != top |=> s_r.cnt == $past(s_r.cnt) + `CNT_ONE)
      else $error("fast mode count did not advance");
   a_fast_set: assert property (
      kind == KIND_FAST && hit && s_r.cnt == top && s_r.actA[1] |=> s_r.stA == !$past(s_r.actA[0]))
      else $error("fast mode output wrong at bottom");
   a_fast_clear: assert property (
      kind == KIND_FAST && matchA && s_r.cnt != top && s_r.actA[1]
      |=> s_r.stA == $past(s_r.actA[0]))
      else $error("fast mode output wrong at match");
   a_fast_toggle: assert property (
      kind == KIND_FAST && matchA && s_r.actA == `ACT_TOGGLE |=> s_r.stA != $past(s_r.stA))
      else $error("fast mode output A did not toggle");
   a_pc_count: assert property (
      kind == KIND_PC && hit && s_r.dirUp && s_r.cnt != top && top != `CNT_BOTTOM
      |=> s_r.cnt == $past(s_r.cnt) + `CNT_ONE)
      else $error("phase correct count did not advance");
   a_pc_up_match: assert property (
      kind == KIND_PC && matchA && s_r.actA[1] && s_r.dirUp && s_r.cnt != top
      |=> s_r.stA == $past(s_r.actA[0]))
      else $error("phase correct output wrong on up match");
   a_pc_down_match: assert property (
      kind == KIND_PC && matchA && s_r.actA[1] && !s_r.dirUp && s_r.cnt != `CNT_BOTTOM
      && top != `CNT_BOTTOM |=> s_r.stA == !$past(s_r.actA[0]))
      else $error("phase correct output wrong on down match");
   a_pc_bottom_fix: assert property (
      kind == KIND_PC && hit && !s_r.dirUp && s_r.cnt == `CNT_BOTTOM && top != `CNT_BOTTOM
      && s_r.actA[1] && s_r.ocrA != `CNT_BOTTOM |=> s_r.stA == !$past(s_r.actA[0]))
      else $error("phase correct output not fixed at bottom");
   a_irq_cmpa: assert property (
      matchA && s_r.ien[`FLG_CMPA] && !(regWr && regAddr[2:0] == `OFS_IEN)
      |=> irqReq)
      else $error("compare A interrupt not requested");
   a_chb_flag: assert property (
      matchB |=> s_r.flags[`FLG_CMPB])
      else $error("compare B flag not set");
endmodule

// file: verif/testbench.sv
`timescale 1ns/10ps
`include "timer8_consts.svh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
   import timer8_pkg::*;
   logic              ref_clk;
   logic              rstn;
   logic              timerTick;
   logic [2:0]        regAddr;
   byte_t             regWdata;
   logic              regWr;
   logic              regRd;
   byte_t             regRdata;
   logic              waveOutA;
   logic              waveOeA_n;
   logic              waveOutB;
   logic              waveOeB_n;
   logic              irqReq;
   logic              pinA;
   logic              pinB;
   logic [15:0]       highA;
   logic [15:0]       riseA;
   logic [15:0]       highB;
   logic [15:0]       riseB;
   int                errCount = 0;
   int                totalChecks = 0;
   byte_t             rdVal;
   byte_t             cnt0;
   byte_t             tCtrl [0:10] = '{8'h83, 8'hc3, 8'h83, 8'h83, 8'hc3, 8'h47, 8'h81, 8'hc1, 8'h81, 8'h81, 8'h25};
   byte_t             tCmpa [0:10] = '{8'h40, 8'h40, 8'h00, 8'hff, 8'hff, 8'h3f, 8'h40, 8'h40, 8'h00, 8'hff, 8'h20};
   int                tWin  [0:10] = '{512, 512, 512, 512, 512, 512, 1020, 1020, 1020, 1020, 512};
   logic [15:0]       tHigh [0:10] = '{16'h0082, 16'h017e, 16'h0002, 16'h0200, 16'h0000, 16'h0100,
                                       16'h0100, 16'h02fc, 16'h0000, 16'h03fc, 16'h0100};
   logic [15:0]       tRise [0:10] = '{16'h0002, 16'h0002, 16'h0002, 16'h0000, 16'h0000, 16'h0004,
                                       16'h0002, 16'h0002, 16'h0000, 16'h0000, 16'h0008};

   timer8_waveform_modes u_timer8_waveform_modes (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .timerTick (timerTick),
      .regAddr   (regAddr),
      .regWdata  (regWdata),
      .regWr     (regWr),
      .regRd     (regRd),
      .regRdata  (regRdata),
      .waveOutA  (waveOutA),
      .waveOeA_n (waveOeA_n),
      .waveOutB  (waveOutB),
      .waveOeB_n (waveOeB_n),
      .irqReq    (irqReq)
   );
   wave_load u_load_a (.ref_clk(ref_clk), .rstn(rstn), .waveOut(waveOutA), .waveOe_n(waveOeA_n),
                       .pinLevel(pinA), .highCnt_r(highA), .riseCnt_r(riseA));
   wave_load u_load_b (.ref_clk(ref_clk), .rstn(rstn), .waveOut(waveOutB), .waveOe_n(waveOeB_n),
                       .pinLevel(pinB), .highCnt_r(highB), .riseCnt_r(riseB));

   // ****************************************
   // Bus tasks and measurement
   // ****************************************
   task automatic wr(input logic [2:0] a, input byte_t d);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge ref_clk);
      regWr    <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [2:0] a);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge ref_clk);
      regRd   <= 1'b0;
      #1;
      rdVal = regRdata;
      @(posedge ref_clk);
   endtask

   task automatic meas(input int n, input logic [15:0] eh, input logic [15:0] er, input logic chB);
      logic [15:0] h0;
      logic [15:0] r0;
      h0 = chB ? highB : highA;
      r0 = chB ? riseB : riseA;
      repeat (n) @(posedge ref_clk);
      `CHK((chB ? highB : highA) - h0, eh)
      `CHK((chB ? riseB : riseA) - r0, er)
   endtask

   task automatic stopTest;
      $display("checks %0d mismatches %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   initial begin
      #160000;
      errCount++;
      stopTest();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      timerTick = 1'b0;
      regAddr = 3'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      `CHK(waveOeA_n, 1'b1)
      rd(`OFS_COUNT);
      `CHK(rdVal, 8'h00)
      rd(3'h7);
      `CHK(rdVal, 8'h00)
      $display("reset test done");
      wr(`OFS_PINCTL, 8'h03);
      wr(`OFS_CMPA, 8'h03);
      wr(`OFS_IEN, 8'h02);
      wr(`OFS_CTRL, 8'h42);
      timerTick <= 1'b1;
      repeat (20) @(posedge ref_clk);
      meas(64, 16'h0020, 16'h0008, 1'b0);
      `CHK(irqReq, 1'b1)
      rd(`OFS_FLAGS);
      `CHK(rdVal, 8'h06)
      $display("clear on match test done");
      wr(`OFS_CMPA, 8'h80);
      repeat (100) @(posedge ref_clk);
      timerTick <= 1'b0;
      @(posedge ref_clk);
      rd(`OFS_COUNT);
      cnt0 = rdVal;
      wr(`OFS_CMPA, 8'h10);
      wr(`OFS_COUNT, 8'h00);
      timerTick <= 1'b1;
      repeat (20) @(posedge ref_clk);
      timerTick <= 1'b0;
      @(posedge ref_clk);
      rd(`OFS_COUNT);
      `CHK(rdVal, cnt0 + 8'h14)
      wr(`OFS_FLAGS, 8'h07);
      timerTick <= 1'b1;
      repeat (300) @(posedge ref_clk);
      timerTick <= 1'b0;
      @(posedge ref_clk);
      rd(`OFS_FLAGS);
      `CHK(rdVal[0], 1'b1)
      rd(`OFS_COUNT);
      `CHK(rdVal <= 8'h10, 1'b1)
      $display("missed match test done");
      wr(`OFS_CTRL, 8'h02);
      wr(`OFS_PINCTL, 8'h07);
      repeat (3) @(posedge ref_clk);
      meas(16, 16'h0010, 16'h0000, 1'b0);
      wr(`OFS_PINCTL, 8'h04);
      repeat (3) @(posedge ref_clk);
      `CHK(waveOeA_n, 1'b1)
      `CHK(pinA, 1'b0)
      $display("pin control test done");
      wr(`OFS_PINCTL, 8'h03);
      wr(`OFS_CMPB, 8'h10);
      timerTick <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         wr(`OFS_CMPA, tCmpa[i]);
         wr(`OFS_CTRL, tCtrl[i]);
         repeat (1200) @(posedge ref_clk);
         meas(tWin[i], tHigh[i], tRise[i], tCtrl[i][5]);
         $display("waveform case %0d done", i);
      end
      stopTest();
   end
endmodule

// file: verif/wave_load.sv
`timescale 1ns/10ps
// ****************************************
// External load on one waveform pin
// ****************************************
module wave_load (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        waveOut,
   input  wire logic        waveOe_n,
   output logic             pinLevel,
   output logic [15:0]      highCnt_r,
   output logic [15:0]      riseCnt_r
);
   logic prev_r;

   // Pull-down holds the pin low while it is not driven
   assign pinLevel = waveOe_n ? 1'b0 : waveOut;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         highCnt_r <= 16'h0000;
         riseCnt_r <= 16'h0000;
         prev_r    <= 1'b0;
      end else begin
         highCnt_r <= highCnt_r + {15'h0000, pinLevel};
         riseCnt_r <= riseCnt_r + {15'h0000, pinLevel & ~prev_r};
         prev_r    <= pinLevel;
      end
   end
endmodule
